// >>> rtl/wtc_wake_timer.sv
/*
 * Wake timer control: settings registers, RC oscillator power and
 * calibration, first-event period count and coded second-event delay.
 * Assumes a register block drives the 6-bit offset, strobes and data
 * synchronously to clk_i, and that the radio consumes the event pulses.
 */
`timescale 1ns/1ps

module wtc_wake_timer #(
    parameter int RC_DIV = wtc_pkg::RC_DIV
) (
    // Clock, reset, clock enable
    input  wire logic                  clk_i,
    input  wire logic                  arst_n_i,
    input  wire logic                  ce_i,
    // Register access
    input  wire wtc_pkg::wtc_reg_req_t reg_req_i,
    output logic [7:0]                 reg_rdata_o,
    // Timer run request from the radio
    input  wire logic                  timer_run_i,
    // Events and status
    output logic                       first_event_o,
    output logic                       second_event_o,
    output logic                       rc_osc_pd_o,
    output logic                       rc_osc_cal_enable_busy_o
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CAL,
        ST_FIRST,
        ST_SECOND
    } wtc_state_t;

    ////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // Last prescaler value for each resolution code
    function automatic logic [14:0] step_last(input logic [1:0] res);
        unique case (res)
            2'h0: step_last = 15'h0000;
            2'h1: step_last = 15'h001f;
            2'h2: step_last = 15'h03ff;
            2'h3: step_last = 15'h7fff;
        endcase
    endfunction : step_last

    // Second-event delay in RC periods
    function automatic logic [5:0] delay_periods(input logic [2:0] code);
        unique case (code)
            3'h0: delay_periods = 6'h04;
            3'h1: delay_periods = 6'h06;
            3'h2: delay_periods = 6'h08;
            3'h3: delay_periods = 6'h0c;
            3'h4: delay_periods = 6'h10;
            3'h5: delay_periods = 6'h18;
            3'h6: delay_periods = 6'h20;
            3'h7: delay_periods = 6'h30;
        endcase
    endfunction : delay_periods

    ////////////////////////////////////////////////////////////////////
    // Registers

    wtc_pkg::wtc_ctrl_t ctrl_q, ctrl_d;
    logic [15:0]        period_q, period_d;
    logic [7:0]         rdata_d;
    logic               pd_prev_q;
    logic               cal_start;

    always_comb begin
        ctrl_d   = ctrl_q;
        period_d = period_q;
        rdata_d  = reg_rdata_o;
        if (reg_req_i.wr) begin
            unique case (reg_req_i.addr)
                wtc_pkg::OFF_CTRL: begin
                    ctrl_d.rc_osc_powerdown =
                        reg_req_i.wdata[wtc_pkg::POS_PD];
                    ctrl_d.second_event_delay =
                        reg_req_i.wdata[wtc_pkg::POS_DELAY +: 3];
                    ctrl_d.rc_osc_cal_enable =
                        reg_req_i.wdata[wtc_pkg::POS_CAL_EN];
                    ctrl_d.wake_timer_resolution =
                        reg_req_i.wdata[wtc_pkg::POS_RES +: 2];
                end
                wtc_pkg::OFF_PERIOD_HI: period_d[15:8] = reg_req_i.wdata;
                wtc_pkg::OFF_PERIOD_LO: period_d[7:0]  = reg_req_i.wdata;
                default: ;
            endcase
        end
        if (reg_req_i.rd) begin
            unique case (reg_req_i.addr)
                // Bit 2 is reserved and reads zero
                wtc_pkg::OFF_CTRL: begin
                    rdata_d = '0;
                    rdata_d[wtc_pkg::POS_PD] = ctrl_q.rc_osc_powerdown;
                    rdata_d[wtc_pkg::POS_DELAY +: 3] =
                        ctrl_q.second_event_delay;
                    rdata_d[wtc_pkg::POS_CAL_EN] = ctrl_q.rc_osc_cal_enable;
                    rdata_d[wtc_pkg::POS_RES +: 2] =
                        ctrl_q.wake_timer_resolution;
                end
                wtc_pkg::OFF_PERIOD_HI: rdata_d = period_q[15:8];
                wtc_pkg::OFF_PERIOD_LO: rdata_d = period_q[7:0];
                default:                rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_q.rc_osc_powerdown      <= wtc_pkg::RST_PD;
            ctrl_q.second_event_delay    <= wtc_pkg::RST_DELAY;
            ctrl_q.rc_osc_cal_enable     <= wtc_pkg::RST_CAL_EN;
            ctrl_q.wake_timer_resolution <= wtc_pkg::RST_RES;
            period_q    <= {wtc_pkg::RST_PERIOD_HI, wtc_pkg::RST_PERIOD_LO};
            reg_rdata_o <= 8'h00;
        end else if (ce_i) begin
            ctrl_q      <= ctrl_d;
            period_q    <= period_d;
            reg_rdata_o <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // RC oscillator power and calibration

    logic rc_tick;
    logic cal_busy;
    logic recal;

    // Falling edge of the stored power-down bit starts calibration
    assign cal_start = pd_prev_q && !ctrl_q.rc_osc_powerdown;

    wtc_rc_osc #(
        .DIV         (RC_DIV)
    ) u_rc_osc (
        .clk_i       (clk_i),
        .arst_n_i    (arst_n_i),
        .ce_i        (ce_i),
        .powerdown_i (ctrl_q.rc_osc_powerdown),
        .cal_start_i (cal_start || recal),
        .tick_o      (rc_tick),
        .cal_busy_o  (cal_busy)
    );

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pd_prev_q     <= wtc_pkg::RST_PD;
            rc_osc_pd_o   <= wtc_pkg::RST_PD;
            rc_osc_cal_enable_busy_o <= 1'b0;
        end else if (ce_i) begin
            pd_prev_q     <= ctrl_q.rc_osc_powerdown;
            rc_osc_pd_o   <= ctrl_q.rc_osc_powerdown;
            rc_osc_cal_enable_busy_o <= cal_busy;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Event sequencer

    wtc_state_t  state_q, state_d;
    logic [14:0] pre_q, pre_d;
    logic [15:0] cnt_q, cnt_d;
    logic [5:0]  dly_q, dly_d;
    logic        ev0_d, ev1_d;
    logic [15:0] period_last;

    // A zero period value runs the full 16-bit range
    assign period_last = period_q - 16'h0001;

    always_comb begin
        state_d = state_q;
        pre_d   = pre_q;
        cnt_d   = cnt_q;
        dly_d   = dly_q;
        ev0_d   = 1'b0;
        ev1_d   = 1'b0;
        recal   = 1'b0;
        if (ctrl_q.rc_osc_powerdown || !timer_run_i) begin
            state_d = ST_IDLE;
            pre_d   = '0;
            cnt_d   = '0;
            dly_d   = '0;
        end else begin
            unique case (state_q)
                ST_IDLE: state_d = cal_busy ? ST_CAL : ST_FIRST;
                ST_CAL:  if (!cal_busy) state_d = ST_FIRST;
                ST_FIRST: if (rc_tick && !cal_busy) begin
                    if (pre_q == step_last(ctrl_q.wake_timer_resolution)) begin
                        pre_d = '0;
                        if (cnt_q == period_last) begin
                            cnt_d   = '0;
                            dly_d   = '0;
                            ev0_d   = 1'b1;
                            state_d = ST_SECOND;
                        end else begin
                            cnt_d = cnt_q + 16'h0001;
                        end
                    end else begin
                        pre_d = pre_q + 15'h0001;
                    end
                end
                ST_SECOND: if (rc_tick) begin
                    if (dly_q == delay_periods(
                            ctrl_q.second_event_delay) - 6'h01) begin
                        ev1_d   = 1'b1;
                        // Recalibration trades a few RC periods of drift
                        recal   = ctrl_q.rc_osc_cal_enable;
                        state_d = ST_FIRST;
                    end else begin
                        dly_d = dly_q + 6'h01;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q        <= ST_IDLE;
            pre_q          <= '0;
            cnt_q          <= '0;
            dly_q          <= '0;
            first_event_o  <= 1'b0;
            second_event_o <= 1'b0;
        end else if (ce_i) begin
            state_q        <= state_d;
            pre_q          <= pre_d;
            cnt_q          <= cnt_d;
            dly_q          <= dly_d;
            first_event_o  <= ev0_d;
            second_event_o <= ev1_d;
        end
    end

endmodule : wtc_wake_timer

// >>> shared/wtc_pkg.sv
/*
 * Shared constants and types of the wake timer control block:
 * register offsets, reset values, field positions and divider counts.
 * Assumes the register block presents 6-bit offsets and 8-bit data.
 */
package wtc_pkg;

    // Register offsets
    localparam logic [5:0] OFF_PERIOD_HI = 6'h1e;
    localparam logic [5:0] OFF_PERIOD_LO = 6'h1f;
    localparam logic [5:0] OFF_CTRL      = 6'h20;

    // Reset values
    localparam logic [7:0] RST_PERIOD_HI = 8'h87;
    localparam logic [7:0] RST_PERIOD_LO = 8'h6b;
    localparam logic       RST_PD        = 1'h1;
    localparam logic [2:0] RST_DELAY     = 3'h7;
    localparam logic       RST_CAL_EN    = 1'h1;
    localparam logic [1:0] RST_RES       = 2'h0;

    // Control register field positions
    localparam int POS_PD     = 7;
    localparam int POS_DELAY  = 4;
    localparam int POS_CAL_EN = 3;
    localparam int POS_RES    = 0;

    // Reference clock cycles per RC oscillator period
    localparam int RC_DIV      = 750;
    localparam int RC_DIV_W    = 10;
    // RC periods spent in one calibration run
    localparam int CAL_PERIODS = 4;
    localparam int CAL_W       = 3;

    typedef struct packed {
        logic       rc_osc_powerdown;
        logic [2:0] second_event_delay;
        logic       rc_osc_cal_enable;
        logic [1:0] wake_timer_resolution;
    } wtc_ctrl_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [5:0]  addr;
        logic [7:0]  wdata;
    } wtc_reg_req_t;

endpackage : wtc_pkg

// >>> rtl/wtc_rc_osc.sv
/*
 * RC oscillator model: divides the reference clock into RC period
 * ticks and runs a calibration sequence on request.
 * Assumes the reference clock stands in for the crystal clock.
 */
`timescale 1ns/1ps
module wtc_rc_osc #(
    parameter int DIV = wtc_pkg::RC_DIV
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic ce_i,
    // Control
    input  wire logic powerdown_i,
    input  wire logic cal_start_i,
    // Status
    output logic      tick_o,
    output logic      cal_busy_o
);

    logic [wtc_pkg::RC_DIV_W-1:0] div_q, div_d;
    logic [wtc_pkg::CAL_W-1:0]    cal_q, cal_d;
    logic                         tick_d, busy_d;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        div_d  = div_q;
        cal_d  = cal_q;
        tick_d = 1'b0;
        busy_d = cal_busy_o;
        if (powerdown_i) begin
            // Stopped oscillator loses its phase
            div_d  = '0;
            cal_d  = '0;
            busy_d = 1'b0;
        end else begin
            if (div_q == wtc_pkg::RC_DIV_W'(DIV - 1)) begin
                div_d  = '0;
                tick_d = 1'b1;
            end else begin
                div_d = div_q + 1'b1;
            end
            if (cal_start_i) begin
                busy_d = 1'b1;
                cal_d  = '0;
            end else if (cal_busy_o && tick_d) begin
                if (cal_q == wtc_pkg::CAL_W'(wtc_pkg::CAL_PERIODS - 1)) begin
                    busy_d = 1'b0;
                end else begin
                    cal_d = cal_q + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_q      <= '0;
            cal_q      <= '0;
            tick_o     <= 1'b0;
            cal_busy_o <= 1'b0;
        end else if (ce_i) begin
            div_q      <= div_d;
            cal_q      <= cal_d;
            tick_o     <= tick_d;
            cal_busy_o <= busy_d;
        end
    end

endmodule : wtc_rc_osc

// >>> verification/wtc_wake_timer_asserts.sv
/*
 * Port-level checks of the wake timer control block.
 * Assumes binding to wtc_wake_timer with a small RC_DIV and ce_i high.
 */
`timescale 1ns/1ps
module wtc_wake_timer_asserts #(
    parameter int RC_DIV = wtc_pkg::RC_DIV
) (
    // Clock and reset
    input wire logic                  clk_i,
    input wire logic                  arst_n_i,
    input wire logic                  ce_i,
    // Register access
    input wire wtc_pkg::wtc_reg_req_t reg_req_i,
    input wire logic [7:0]            reg_rdata_o,
    // Timer
    input wire logic                  timer_run_i,
    input wire logic                  first_event_o,
    input wire logic                  second_event_o,
    input wire logic                  rc_osc_pd_o,
    input wire logic                  rc_osc_cal_enable_busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    ////////////////////////////////////////////////////////////////////
    // Event phase tracker: cleared whenever the timer is idled
    logic phase_q;
    logic phase_d;
    always_comb begin
        phase_d = phase_q;
        if (first_event_o) phase_d = 1'b1;
        if (second_event_o || rc_osc_pd_o || !timer_run_i) phase_d = 1'b0;
    end
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) phase_q <= 1'b0;
        else phase_q <= phase_d;
    end
    ////////////////////////////////////////////////////////////////////
    AST_PD_SET: assert property (ce_i && reg_req_i.wr &&
        reg_req_i.wdata[7] && reg_req_i.addr == wtc_pkg::OFF_CTRL
        |-> ##2 rc_osc_pd_o)
        else $error("power-down not applied");
    AST_PD_HOLD: assert property (rc_osc_pd_o && $past(rc_osc_pd_o)
        |-> !first_event_o && !second_event_o)
        else $error("event while powered down");
    AST_PD_READ: assert property (reg_req_i.rd &&
        reg_req_i.addr == wtc_pkg::OFF_CTRL
        |=> reg_rdata_o[7] == rc_osc_pd_o && !reg_rdata_o[2])
        else $error("control read mismatch");
    AST_PD_FALL: assert property ($fell(rc_osc_pd_o) |->
        $past(reg_req_i.wr, 2) && !$past(reg_req_i.wdata[7], 2))
        else $error("power-up without write");
    AST_CAL_START: assert property ($fell(rc_osc_pd_o) |=> rc_osc_cal_enable_busy_o)
        else $error("no calibration on power-up");
    AST_CAL_LEN: assert property ($rose(rc_osc_cal_enable_busy_o) |->
        rc_osc_cal_enable_busy_o[*8] ##[1:600] !rc_osc_cal_enable_busy_o)
        else $error("calibration length wrong");
    AST_CAL_NO_EVT: assert property (rc_osc_cal_enable_busy_o |-> !first_event_o)
        else $error("first event during calibration");
    AST_ORDER_FIRST: assert property (first_event_o |-> !phase_q)
        else $error("first event out of order");
    AST_ORDER_SECOND: assert property (second_event_o |-> phase_q)
        else $error("second event out of order");
    COV_FIRST: cover property (first_event_o);
    COV_SECOND: cover property (second_event_o);
    COV_CAL: cover property ($fell(rc_osc_cal_enable_busy_o));
endmodule : wtc_wake_timer_asserts

// >>> verification/tb_top.sv
/*
 * Self-checking bench of the wake timer control block.
 * Assumes RC_DIV shortened to 4; resolution code 3 is too long to run.
 */
`timescale 1ns/1ps
module tb_top;
    localparam int DIV = 4;
    logic                  clk_i       = 1'b0;
    logic                  arst_n_i    = 1'b0;
    logic                  ce_i        = 1'b1;
    logic                  timer_run_i = 1'b0;
    wtc_pkg::wtc_reg_req_t reg_req_i   = '0;
    logic [7:0]            reg_rdata_o;
    logic                  first_event_o;
    logic                  second_event_o;
    logic                  rc_osc_pd_o;
    logic                  rc_osc_cal_enable_busy_o;
    int                    error_cnt   = 0;
    int                    checks_done = 0;
    int                    dly[8]      = '{4, 6, 8, 12, 16, 24, 32, 48};
    always #25 clk_i = ~clk_i;
    wtc_wake_timer #(.RC_DIV(DIV)) i_dut (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
        .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
        .timer_run_i(timer_run_i), .first_event_o(first_event_o),
        .second_event_o(second_event_o), .rc_osc_pd_o(rc_osc_pd_o),
        .rc_osc_cal_enable_busy_o(rc_osc_cal_enable_busy_o));
    ////////////////////////////////////////////////////////////////////
    task automatic fail(string msg);
        error_cnt++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask : fail
    task automatic chk8(logic [7:0] got, logic [7:0] exp, string what);
        checks_done++;
        if (got !== exp) fail(what);
    endtask : chk8
    task automatic chk_cnt(int got, int exp, int tol, string what);
        checks_done++;
        if (got < exp - tol || got > exp + tol) fail(what);
    endtask : chk_cnt
    // One idle cycle after each access keeps drives one per time step
    task automatic wr(logic [5:0] a, logic [7:0] d);
        reg_req_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk_i);
        reg_req_i = '0;
        @(negedge clk_i);
    endtask : wr
    task automatic rd(logic [5:0] a, logic [7:0] exp);
        reg_req_i = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk_i);
        reg_req_i = '0;
        chk8(reg_rdata_o, exp, "read data");
        @(negedge clk_i);
    endtask : rd
    // Cycles until the selected output is seen high, bounded
    task automatic meas(int sel, int exp, int tol, string what);
        int  c;
        logic s;
        c = 0;
        s = 1'b0;
        while (s !== 1'b1 && c < 20000) begin
            s = sel == 1 ? first_event_o :
                sel == 2 ? second_event_o : rc_osc_cal_enable_busy_o;
            if (s !== 1'b1) @(negedge clk_i);
            if (s !== 1'b1) c++;
        end
        chk_cnt(c, exp, tol, what);
    endtask : meas
    task automatic run_case(logic [2:0] code, logic [1:0] res);
        int step;
        step = 1 << (5 * res);
        wr(wtc_pkg::OFF_CTRL, {1'b1, code, 2'h0, res});
        wr(wtc_pkg::OFF_CTRL, {1'b0, code, 2'h0, res});
        meas(1, (4 + 2 * step) * DIV, DIV + 6, "first after cal");
        meas(2, dly[code] * DIV, 1, "second delay");
        meas(1, 2 * step * DIV, 1, "first restart");
    endtask : run_case
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////
    initial begin
        #4_000_000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        repeat (20) @(negedge clk_i);
        arst_n_i = 1'b1;
        @(negedge clk_i);
        rd(wtc_pkg::OFF_PERIOD_HI, 8'h87);
        rd(wtc_pkg::OFF_PERIOD_LO, 8'h6b);
        rd(wtc_pkg::OFF_CTRL, 8'hf8);
        rd(6'h21, 8'h00);
        chk8({7'h00, rc_osc_pd_o}, 8'h01, "power-down flag");
        $display("test reset values done");
        wr(wtc_pkg::OFF_CTRL, 8'hf7);
        rd(wtc_pkg::OFF_CTRL, 8'hf3);
        wr(6'h21, 8'h55);
        rd(wtc_pkg::OFF_CTRL, 8'hf3);
        wr(wtc_pkg::OFF_PERIOD_HI, 8'h00);
        wr(wtc_pkg::OFF_PERIOD_LO, 8'h02);
        rd(wtc_pkg::OFF_PERIOD_HI, 8'h00);
        rd(wtc_pkg::OFF_PERIOD_LO, 8'h02);
        $display("test register access done");
        timer_run_i = 1'b1;
        for (int k = 0; k < 8; k++) run_case(k[2:0], 2'h0);
        $display("test delay codes done");
        run_case(3'h0, 2'h1);
        run_case(3'h0, 2'h2);
        $display("test resolutions done");
        wr(wtc_pkg::OFF_CTRL, 8'h88);
        wr(wtc_pkg::OFF_CTRL, 8'h08);
        meas(1, 6 * DIV, DIV + 6, "first after cal");
        meas(2, 4 * DIV, 1, "second delay");
        meas(3, 0, 3, "recalibration");
        $display("test recalibration done");
        timer_run_i = 1'b0;
        repeat (100) @(negedge clk_i);
        // A write while the clock enable is low must leave no trace
        ce_i = 1'b0;
        wr(wtc_pkg::OFF_CTRL, 8'h80);
        ce_i = 1'b1;
        rd(wtc_pkg::OFF_CTRL, 8'h08);
        chk8({7'h00, rc_osc_pd_o}, 8'h00, "power-down frozen");
        wr(wtc_pkg::OFF_CTRL, 8'h80);
        rd(wtc_pkg::OFF_CTRL, 8'h80);
        chk8({7'h00, rc_osc_pd_o}, 8'h01, "power-down flag");
        $display("test idle done");
        give_verdict();
    end
endmodule : tb_top
bind wtc_wake_timer wtc_wake_timer_asserts #(.RC_DIV(RC_DIV)) i_chk (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
    .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
    .timer_run_i(timer_run_i), .first_event_o(first_event_o),
    .second_event_o(second_event_o), .rc_osc_pd_o(rc_osc_pd_o),
    .rc_osc_cal_enable_busy_o(rc_osc_cal_enable_busy_o));
